// File: src/usb_fifo_port_regs.svh
/*
 * Constants for the byte-wide parallel FIFO port: buffer size and flag timing.
 * Assumes it is included by bare name from files that need these figures.
 */
`ifndef USB_FIFO_PORT_REGS_SVH
`define USB_FIFO_PORT_REGS_SVH

// ********************************************************************
// buffers
// ********************************************************************
`define UFP_DEPTH_LOG2    10
`define UFP_DATA_W        8

// ********************************************************************
// link timing
// ********************************************************************
`define UFP_LINK_PERIOD_PS 16670
`define UFP_FLAG_HOLD_NS   49
`define UFP_FLAG_HOLD_CYC  ((`UFP_FLAG_HOLD_NS * 1000 + `UFP_LINK_PERIOD_PS - 1) / `UFP_LINK_PERIOD_PS)
`define UFP_HOLD_CNT_W     3

`endif

// File: src/usb_fifo_port_pkg.sv
/*
 * Types shared by the parallel FIFO port: pin bundles, byte beats, strobe phases.
 * Assumes the constants header is compiled alongside it.
 */
package usb_fifo_port_pkg;

	// ********************************************************************
	// carriers
	// ********************************************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_beat_t;

	typedef struct packed {
		logic       rd_n;
		logic       wr_n;
		logic       oe_n;
		logic [7:0] data;
	} pins_in_t;

	typedef struct packed {
		logic       rx_data_avail_n;
		logic       tx_space_avail_n;
		logic [7:0] data;
		logic       data_oe;
	} pins_out_t;

	// ********************************************************************
	// strobe phases in asynchronous mode
	// ********************************************************************
	typedef enum logic [1:0] {
		STB_IDLE,
		STB_ACTIVE,
		STB_HOLD
	} strobe_state_t;

endpackage

// File: src/byte_ram.sv
/*
 * Simple dual-clock dual-port memory with a registered read port.
 * Assumes the caller keeps reads and writes of the same word apart in time.
 */
`timescale 1ns/1ps

module byte_ram #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	input  wire logic          i_wr_clk,
	input  wire logic          i_wr_en,
	input  wire logic [AW-1:0] i_wr_addr,
	input  wire logic [DW-1:0] i_wr_data,
	input  wire logic          i_rd_clk,
	input  wire logic          i_rd_en,
	input  wire logic [AW-1:0] i_rd_addr,
	output logic      [DW-1:0] o_rd_data
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge i_wr_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	// no reset on the read register: it is a memory output, qualified by valid flags
	always_ff @(posedge i_rd_clk) begin
		if (i_rd_en) begin
			o_rd_data <= mem[i_rd_addr];
		end
	end

endmodule // byte_ram

// File: src/bit_sync.sv
/*
 * Two-flip-flop level synchroniser with asynchronous reset to a chosen value.
 * Assumes each bit is a level or a gray-coded word changing one bit at a time.
 */
`timescale 1ns/1ps

module bit_sync #(
	parameter int                 WIDTH   = 1,
	parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= RST_VAL;
			o_q    <= RST_VAL;
		end else begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end

endmodule // bit_sync

// File: src/usb_parallel_fifo_port.sv
/*
 * Byte-wide parallel FIFO port between the bridge core and an external master.
 * Two 1 KiB dual-clock buffers, synchronous (clock-out) and asynchronous (strobe)
 * modes. Assumes i_fifo_clk is a free-running ~60 MHz clock from the device's
 * own clock generator and that sync-mode pins are timed to o_fifo_clock_out.
 */
`timescale 1ns/1ps
`include "usb_fifo_port_regs.svh"

module usb_parallel_fifo_port #(
	parameter int DEPTH_LOG2 = `UFP_DEPTH_LOG2
) (
	input  wire logic                          i_core_clk,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_fifo_clk,
	input  wire logic                          i_sync_mode,
	input  wire usb_fifo_port_pkg::byte_beat_t i_dn,
	output logic                               o_dn_ready,
	output usb_fifo_port_pkg::byte_beat_t      o_up,
	input  wire logic                          i_up_ready,
	input  wire usb_fifo_port_pkg::pins_in_t   i_pins,
	output usb_fifo_port_pkg::pins_out_t       o_pins,
	output logic                               o_fifo_clock_out
);
	import usb_fifo_port_pkg::*;

	localparam int             PW      = DEPTH_LOG2 + 1;
	localparam int             DW      = `UFP_DATA_W;
	localparam logic [PW-1:0]  DEPTH_P = PW'(1) << DEPTH_LOG2;
	localparam logic [`UFP_HOLD_CNT_W-1:0] HOLD_LAST = `UFP_HOLD_CNT_W'(`UFP_FLAG_HOLD_CYC - 1);

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = '0;
		for (int i = PW - 1; i >= 0; i--) begin
			b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
		end
		return b;
	endfunction

	// ********************************************************************
	// link-domain reset and mode
	// ********************************************************************
	logic link_rst_n;
	logic sync_mode_l;

	bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_link_rst (
		.i_clk   (i_fifo_clk),
		.i_rst_n (i_rst_n),
		.i_d     (1'b1),
		.o_q     (link_rst_n)
	);

	bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_mode_sync (
		.i_clk   (i_fifo_clk),
		.i_rst_n (link_rst_n),
		.i_d     (i_sync_mode),
		.o_q     (sync_mode_l)
	);

	// mode is meant to be static; switching it mid-transfer may glitch the clock out
	assign o_fifo_clock_out = sync_mode_l ? i_fifo_clk : 1'b0;

	// ********************************************************************
	// down buffer: core writes, port master reads
	// ********************************************************************
	logic [PW-1:0] dn_wptr_r;
	logic [PW-1:0] dn_wgray_r;
	logic [PW-1:0] dn_rgray_s;
	logic [PW-1:0] dn_rptr_r;
	logic [PW-1:0] dn_rgray_r;
	logic [PW-1:0] dn_wgray_s;
	logic          dn_full;
	logic          dn_push;
	logic          dn_empty;
	logic          dn_head_vld_r;
	logic          dn_pop;
	logic          dn_load;
	logic [DW-1:0] dn_head;

	assign dn_full    = dn_wgray_r == {~dn_rgray_s[PW-1:PW-2], dn_rgray_s[PW-3:0]};
	assign o_dn_ready = !dn_full;
	assign dn_push    = i_dn.valid && !dn_full;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dn_wptr_r  <= '0;
			dn_wgray_r <= '0;
		end else if (dn_push) begin
			dn_wptr_r  <= dn_wptr_r + PW'(1);
			dn_wgray_r <= bin2gray(dn_wptr_r + PW'(1));
		end
	end

	bit_sync #(.WIDTH(PW), .RST_VAL('0)) u_dn_rptr_sync (
		.i_clk   (i_core_clk),
		.i_rst_n (i_rst_n),
		.i_d     (dn_rgray_r),
		.o_q     (dn_rgray_s)
	);

	bit_sync #(.WIDTH(PW), .RST_VAL('0)) u_dn_wptr_sync (
		.i_clk   (i_fifo_clk),
		.i_rst_n (link_rst_n),
		.i_d     (dn_wgray_r),
		.o_q     (dn_wgray_s)
	);

	// the ram read register is the byte on the bus; loading it on a pop keeps bursts gapless
	assign dn_empty = dn_rgray_r == dn_wgray_s;
	assign dn_load  = !dn_empty && (!dn_head_vld_r || dn_pop);

	byte_ram #(.AW(DEPTH_LOG2), .DW(DW)) u_dn_ram (
		.i_wr_clk  (i_core_clk),
		.i_wr_en   (dn_push),
		.i_wr_addr (dn_wptr_r[DEPTH_LOG2-1:0]),
		.i_wr_data (i_dn.data),
		.i_rd_clk  (i_fifo_clk),
		.i_rd_en   (dn_load),
		.i_rd_addr (dn_rptr_r[DEPTH_LOG2-1:0]),
		.o_rd_data (dn_head)
	);

	always_ff @(posedge i_fifo_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			dn_rptr_r     <= '0;
			dn_rgray_r    <= '0;
			dn_head_vld_r <= 1'b0;
		end else begin
			if (dn_load) begin
				dn_rptr_r     <= dn_rptr_r + PW'(1);
				dn_rgray_r    <= bin2gray(dn_rptr_r + PW'(1));
				dn_head_vld_r <= 1'b1;
			end else if (dn_pop) begin
				dn_head_vld_r <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// up buffer: port master writes, core reads
	// ********************************************************************
	logic [PW-1:0] up_wptr_r;
	logic [PW-1:0] up_wgray_r;
	logic [PW-1:0] up_rgray_s;
	logic [PW-1:0] up_wptr_nxt;
	logic          up_full_r;
	logic          up_push;
	logic [DW-1:0] up_wdata;
	logic [PW-1:0] up_rptr_r;
	logic [PW-1:0] up_rgray_r;
	logic [PW-1:0] up_wgray_s;
	logic          up_empty;
	logic          up_vld_r;
	logic          up_pop;
	logic          up_load;
	logic [DW-1:0] up_q;

	assign up_wptr_nxt = up_wptr_r + PW'(up_push);

	always_ff @(posedge i_fifo_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			up_wptr_r  <= '0;
			up_wgray_r <= '0;
			up_full_r  <= 1'b1;
		end else begin
			up_wptr_r  <= up_wptr_nxt;
			up_wgray_r <= bin2gray(up_wptr_nxt);
			// counted against the pointer after this push, so the flag rises in time
			up_full_r  <= (up_wptr_nxt - gray2bin(up_rgray_s)) == DEPTH_P;
		end
	end

	bit_sync #(.WIDTH(PW), .RST_VAL('0)) u_up_rptr_sync (
		.i_clk   (i_fifo_clk),
		.i_rst_n (link_rst_n),
		.i_d     (up_rgray_r),
		.o_q     (up_rgray_s)
	);

	bit_sync #(.WIDTH(PW), .RST_VAL('0)) u_up_wptr_sync (
		.i_clk   (i_core_clk),
		.i_rst_n (i_rst_n),
		.i_d     (up_wgray_r),
		.o_q     (up_wgray_s)
	);

	byte_ram #(.AW(DEPTH_LOG2), .DW(DW)) u_up_ram (
		.i_wr_clk  (i_fifo_clk),
		.i_wr_en   (up_push),
		.i_wr_addr (up_wptr_r[DEPTH_LOG2-1:0]),
		.i_wr_data (up_wdata),
		.i_rd_clk  (i_core_clk),
		.i_rd_en   (up_load),
		.i_rd_addr (up_rptr_r[DEPTH_LOG2-1:0]),
		.o_rd_data (up_q)
	);

	assign up_empty = up_rgray_r == up_wgray_s;
	assign up_pop   = up_vld_r && i_up_ready;
	assign up_load  = !up_empty && (!up_vld_r || up_pop);
	assign o_up     = {up_vld_r, up_q};

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			up_rptr_r  <= '0;
			up_rgray_r <= '0;
			up_vld_r   <= 1'b0;
		end else begin
			if (up_load) begin
				up_rptr_r  <= up_rptr_r + PW'(1);
				up_rgray_r <= bin2gray(up_rptr_r + PW'(1));
				up_vld_r   <= 1'b1;
			end else if (up_pop) begin
				up_vld_r   <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// asynchronous strobe sampling
	// ********************************************************************
	logic [1:0]    strb_s;
	logic [1:0]    strb_d_r;
	logic [DW-1:0] dat_p1_r;
	logic [DW-1:0] dat_p2_r;
	logic          a_rd_fall;
	logic          a_rd_rise;
	logic          a_wr_fall;
	logic          a_wr_rise;

	bit_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_strobe_sync (
		.i_clk   (i_fifo_clk),
		.i_rst_n (link_rst_n),
		.i_d     ({i_pins.rd_n, i_pins.wr_n}),
		.o_q     (strb_s)
	);

	// data runs through the same depth as the strobes so the captured byte lines up
	always_ff @(posedge i_fifo_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			strb_d_r <= 2'b11;
			dat_p1_r <= '0;
			dat_p2_r <= '0;
		end else begin
			strb_d_r <= strb_s;
			dat_p1_r <= i_pins.data;
			dat_p2_r <= dat_p1_r;
		end
	end

	assign a_rd_fall = !sync_mode_l && strb_d_r[1] && !strb_s[1];
	assign a_rd_rise = !sync_mode_l && !strb_d_r[1] && strb_s[1];
	assign a_wr_fall = !sync_mode_l && strb_d_r[0] && !strb_s[0] && strb_s[1];
	assign a_wr_rise = !sync_mode_l && !strb_d_r[0] && strb_s[0];

	// ********************************************************************
	// asynchronous read and write phases
	// ********************************************************************
	strobe_state_t               rd_st_r;
	strobe_state_t               wr_st_r;
	logic [`UFP_HOLD_CNT_W-1:0]  rd_cnt_r;
	logic [`UFP_HOLD_CNT_W-1:0]  wr_cnt_r;
	logic                        rx_flag_n;
	logic                        tx_flag_n;
	logic                        sy_rd_pop;
	logic                        sy_wr_push;
	logic                        a_wr_push;

	always_ff @(posedge i_fifo_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rd_st_r  <= STB_IDLE;
			rd_cnt_r <= '0;
		end else begin
			case (rd_st_r)
				STB_IDLE: begin
					if (a_rd_fall && dn_head_vld_r) begin
						rd_st_r <= STB_ACTIVE;
					end
				end
				STB_ACTIVE: begin
					if (a_rd_rise) begin
						rd_st_r  <= STB_HOLD;
						rd_cnt_r <= HOLD_LAST;
					end
				end
				STB_HOLD: begin
					if (rd_cnt_r == '0) begin
						rd_st_r <= STB_IDLE;
					end else begin
						rd_cnt_r <= rd_cnt_r - `UFP_HOLD_CNT_W'(1);
					end
				end
				default: rd_st_r <= STB_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_fifo_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			wr_st_r  <= STB_IDLE;
			wr_cnt_r <= '0;
		end else begin
			case (wr_st_r)
				STB_IDLE: begin
					if (a_wr_fall) begin
						wr_st_r <= STB_ACTIVE;
					end
				end
				STB_ACTIVE: begin
					if (a_wr_rise) begin
						wr_st_r  <= STB_HOLD;
						wr_cnt_r <= HOLD_LAST;
					end
				end
				STB_HOLD: begin
					if (wr_cnt_r == '0) begin
						wr_st_r <= STB_IDLE;
					end else begin
						wr_cnt_r <= wr_cnt_r - `UFP_HOLD_CNT_W'(1);
					end
				end
				default: wr_st_r <= STB_IDLE;
			endcase
		end
	end

	// ********************************************************************
	// transfers and pins
	// ********************************************************************
	// sync-mode pins are timed to our own clock out, so they are sampled directly
	assign sy_rd_pop  = sync_mode_l && !i_pins.rd_n && !i_pins.oe_n && dn_head_vld_r;
	assign sy_wr_push = sync_mode_l && !i_pins.wr_n && i_pins.rd_n && !tx_flag_n;
	// a write strobe against a full buffer is dropped; the flag already said no room
	assign a_wr_push  = a_wr_fall && wr_st_r == STB_IDLE && !up_full_r;

	assign dn_pop   = sy_rd_pop || (rd_st_r == STB_ACTIVE && a_rd_rise);
	assign up_push  = sy_wr_push || a_wr_push;
	assign up_wdata = sync_mode_l ? i_pins.data : dat_p2_r;

	assign rx_flag_n = !dn_head_vld_r || rd_st_r == STB_HOLD;
	assign tx_flag_n = up_full_r || wr_st_r != STB_IDLE;

	assign o_pins.rx_data_avail_n  = rx_flag_n;
	assign o_pins.tx_space_avail_n = tx_flag_n;
	assign o_pins.data             = dn_head;
	// async mode ignores output enable; the bus turns with the read strobe only
	assign o_pins.data_oe          = sync_mode_l ? !i_pins.oe_n : rd_st_r == STB_ACTIVE;

endmodule // usb_parallel_fifo_port

// File: tb/usb_parallel_fifo_port_properties.sv
/* Concurrent checks on the parallel FIFO port, bound to the top module's ports.
 * Assumes the mode input changes only while reset is held. */
`timescale 1ns/1ps

module usb_parallel_fifo_port_properties #(
	parameter int DEPTH_LOG2 = 10
) (
	input wire logic                          i_core_clk,
	input wire logic                          i_rst_n,
	input wire logic                          i_fifo_clk,
	input wire logic                          i_sync_mode,
	input wire usb_fifo_port_pkg::byte_beat_t o_up,
	input wire logic                          i_up_ready,
	input wire usb_fifo_port_pkg::pins_in_t   i_pins,
	input wire usb_fifo_port_pkg::pins_out_t  o_pins,
	input wire logic                          o_fifo_clock_out
);
	import usb_fifo_port_pkg::*;
	// the link side needs a few edges to learn the mode, so its checks wait
	logic [3:0] settle_r;
	logic       settled;
	always_ff @(posedge i_fifo_clk or negedge i_rst_n) begin
		if (!i_rst_n) settle_r <= 4'h0;
		else if (settle_r != 4'h8) settle_r <= settle_r + 4'h1;
	end
	assign settled = (settle_r == 4'h8);

	a_async_no_clock: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_sync_mode |-> !o_fifo_clock_out) else $error("clock out runs in async mode");
	a_up_hold_data: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_up.valid && !i_up_ready |=> o_up.valid && $stable(o_up.data))
		else $error("core byte dropped before taken");
	a_async_oe_ignored: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		(settled && !i_sync_mode && i_pins.rd_n)[*6] |-> !o_pins.data_oe)
		else $error("bus driven without read strobe");
	a_sync_oe_follow: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && i_sync_mode |-> o_pins.data_oe == !i_pins.oe_n)
		else $error("bus enable not following output enable");
	a_sync_rd_stable: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && i_sync_mode && !o_pins.rx_data_avail_n && i_pins.rd_n |=> $stable(o_pins.data))
		else $error("read data moved without a read");
	a_async_data_stable: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && !i_sync_mode && o_pins.data_oe && $past(o_pins.data_oe) |-> $stable(o_pins.data))
		else $error("async read data moved during strobe");
	a_async_rx_drop: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && !i_sync_mode && $rose(i_pins.rd_n) && o_pins.data_oe
		|-> ##[1:6] o_pins.rx_data_avail_n) else $error("data flag not dropped after read");
	a_async_rx_hold: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && !i_sync_mode && $rose(o_pins.rx_data_avail_n) |-> o_pins.rx_data_avail_n[*3])
		else $error("data flag back too soon");
	a_async_tx_drop: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && !i_sync_mode && $fell(i_pins.wr_n) && i_pins.rd_n && !o_pins.tx_space_avail_n
		|-> ##[1:6] o_pins.tx_space_avail_n) else $error("space flag not dropped on write");
	a_async_tx_hold: assert property (@(posedge i_fifo_clk) disable iff (!i_rst_n)
		settled && !i_sync_mode && $rose(o_pins.tx_space_avail_n) |-> o_pins.tx_space_avail_n[*3])
		else $error("space flag back too soon");
endmodule // usb_parallel_fifo_port_properties

// File: tb/fifo_master_model.sv
/* External FIFO master driving the port's pins, one task per kind of transfer.
 * Assumes tasks are entered off the link clock's rising edge. */
`timescale 1ns/1ps

module fifo_master_model (
	input  wire logic                         i_clk,
	input  wire usb_fifo_port_pkg::pins_out_t i_pins,
	input  wire logic [7:0]                   i_bus,
	output usb_fifo_port_pkg::pins_in_t       o_pins
);
	import usb_fifo_port_pkg::*;
	int hangs;
	initial begin
		hangs = 0;
		o_pins = {1'b1, 1'b1, 1'b1, 8'hA5};
	end
	// a released bus shows the inverse so a stale byte never passes
	task automatic release_bus();
		o_pins.data = ~o_pins.data;
	endtask
	task automatic wait_low(input bit rx);
		int k;
		k = 0;
		while ((rx ? i_pins.rx_data_avail_n : i_pins.tx_space_avail_n) !== 1'b0 && k < 500) begin
			@(negedge i_clk);
			k++;
		end
		if (k == 500) hangs++;
	endtask
	task automatic async_read(output logic [7:0] d);
		wait_low(1'b1);
		o_pins.rd_n = 1'b0;
		repeat (6) @(negedge i_clk);
		d = i_bus;
		o_pins.rd_n = 1'b1;
		repeat (8) @(negedge i_clk);
	endtask
	task automatic async_write(input logic [7:0] d);
		wait_low(1'b0);
		o_pins.data = d;
		@(negedge i_clk);
		o_pins.wr_n = 1'b0;
		repeat (6) @(negedge i_clk);
		o_pins.wr_n = 1'b1;
		@(negedge i_clk);
		release_bus();
		repeat (7) @(negedge i_clk);
	endtask
	task automatic sync_open();
		wait_low(1'b1);
		o_pins.oe_n = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic sync_read(output logic [7:0] d);
		o_pins.rd_n = 1'b0;
		wait_low(1'b1);
		d = i_bus;
		@(negedge i_clk);
	endtask
	task automatic sync_pause();
		o_pins.rd_n = 1'b1;
		@(negedge i_clk);
	endtask
	task automatic sync_write(input logic [7:0] d, output bit t);
		o_pins.data = d;
		o_pins.wr_n = 1'b0;
		t = (i_pins.tx_space_avail_n === 1'b0);
		@(negedge i_clk);
	endtask
	task automatic sync_idle();
		o_pins.rd_n = 1'b1;
		o_pins.wr_n = 1'b1;
		o_pins.oe_n = 1'b1;
		release_bus();
		@(negedge i_clk);
	endtask
endmodule // fifo_master_model

// File: tb/usb_parallel_fifo_port_tb.sv
/* Bench for the parallel FIFO port: queue model of both streams, master model on pins.
 * Assumes design, master model and checker are compiled before it. */
`timescale 1ns/1ps

module usb_parallel_fifo_port_tb;
	import usb_fifo_port_pkg::*;
	localparam int DL2   = 4;
	localparam int DEPTH = 1 << DL2;
	logic       core_clk, link_clk, rst_n, sync_mode, up_ready, dn_ready, clk_out, stall;
	byte_beat_t dn, up;
	pins_in_t   pins_m, pins_i;
	pins_out_t  pins_o;
	logic [7:0] bus, d, exp_dn[$], exp_up[$];
	int         miscompares, total_checks, hangs, n;
	bit         t;

	assign bus = pins_o.data_oe ? pins_o.data : pins_m.data;
	assign pins_i = {pins_m.rd_n, pins_m.wr_n, pins_m.oe_n, bus};
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	usb_parallel_fifo_port #(.DEPTH_LOG2(DL2)) dut_u (.i_core_clk(core_clk), .i_rst_n(rst_n),
		.i_fifo_clk(link_clk), .i_sync_mode(sync_mode), .i_dn(dn), .o_dn_ready(dn_ready),
		.o_up(up), .i_up_ready(up_ready), .i_pins(pins_i), .o_pins(pins_o),
		.o_fifo_clock_out(clk_out));
	fifo_master_model m_u (.i_clk(link_clk), .i_pins(pins_o), .i_bus(bus), .o_pins(pins_m));

	// ********************************************************************
	// checking and verdict
	// ********************************************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (hangs + m_u.hangs != 0) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		repeat (90000) @(posedge core_clk);
		hangs++;
	end
	// core receiver stalls at random so the up buffer backs up
	always @(negedge core_clk) begin
		up_ready = !stall && ($urandom % 4 != 0);
		if (rst_n && up.valid === 1'b1 && up_ready) begin
			if (exp_up.size() == 0) check(up.data, ~up.data);
			else check(up.data, exp_up.pop_front());
		end
	end

	// ********************************************************************
	// drivers
	// ********************************************************************
	task automatic do_reset(input logic mode);
		@(negedge core_clk);
		rst_n = 1'b0;
		sync_mode = mode;
		repeat (16) @(negedge core_clk);
		check({4'h0, pins_o.rx_data_avail_n, pins_o.tx_space_avail_n, dn_ready, up.valid}, 8'h0E);
		rst_n = 1'b1;
		repeat (8) @(negedge link_clk);
	endtask
	task automatic core_send(input int cnt, output int taken);
		taken = 0;
		repeat (cnt) begin
			@(negedge core_clk);
			dn.valid = 1'b1;
			dn.data = $urandom;
			if (dn_ready === 1'b1) begin
				exp_dn.push_back(dn.data);
				taken++;
			end
		end
		@(negedge core_clk);
		dn.valid = 1'b0;
	endtask
	task automatic wait_drain();
		int k;
		k = 0;
		while (exp_up.size() != 0 && k < 3000) begin
			@(negedge core_clk);
			k++;
		end
		if (k == 3000) hangs++;
	endtask

	initial begin
		void'($urandom(32'h4AF0));
		miscompares = 0;
		total_checks = 0;
		hangs = 0;
		dn = '0;
		stall = 1'b1;
		up_ready = 1'b0;
		rst_n = 1'b0;
		sync_mode = 1'b0;
		do_reset(1'b0);
		m_u.o_pins.oe_n = 1'b0;
		core_send(4, n);
		stall = 1'b0;
		for (int i = 0; i < 4; i++) begin
			m_u.async_read(d);
			check(d, exp_dn.pop_front());
		end
		repeat (4) begin
			d = $urandom;
			exp_up.push_back(d);
			m_u.async_write(d);
		end
		wait_drain();
		m_u.sync_idle();
		do_reset(1'b1);
		repeat (3) begin
			@(posedge link_clk);
			#1 check({7'h00, clk_out}, 8'h01);
			@(negedge link_clk);
			#1 check({7'h00, clk_out}, 8'h00);
		end
		core_send(DEPTH + 4, n);
		// the read register in front of the bus holds one byte beyond the memory depth
		check(n[7:0], 8'(DEPTH + 1));
		m_u.sync_open();
		check(bus, exp_dn[0]);
		for (int i = 0; i < DEPTH + 1; i++) begin
			if (i == 0) m_u.o_pins.wr_n = 1'b0;
			m_u.sync_read(d);
			m_u.o_pins.wr_n = 1'b1;
			check(d, exp_dn.pop_front());
			if ($urandom % 3 == 0) m_u.sync_pause();
		end
		m_u.sync_idle();
		check({7'h00, pins_o.rx_data_avail_n}, 8'h01);
		stall = 1'b1;
		n = 0;
		for (int i = 0; i < DEPTH + 4; i++) begin
			d = $urandom;
			m_u.sync_write(d, t);
			if (t) exp_up.push_back(d);
			n += t;
		end
		m_u.sync_idle();
		check(n[7:0], 8'(DEPTH + 1));
		stall = 1'b0;
		wait_drain();
		print_verdict();
	end
endmodule // usb_parallel_fifo_port_tb

bind usb_parallel_fifo_port usb_parallel_fifo_port_properties #(.DEPTH_LOG2(DEPTH_LOG2)) chk_u (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_fifo_clk(i_fifo_clk),
	.i_sync_mode(i_sync_mode), .o_up(o_up), .i_up_ready(i_up_ready), .i_pins(i_pins),
	.o_pins(o_pins), .o_fifo_clock_out(o_fifo_clock_out));
